// ==== hdl/sirq_defs.svh ====
/*
 serial interrupt wire agent: timing and field constants.
 assumes inclusion by bare name from design files only.
*/
`ifndef SIRQ_DEFS_SVH
`define SIRQ_DEFS_SVH
`define SIRQ_CLK_NS        40
`define SIRQ_FRAME_CLKS    3
`define SIRQ_LAST_FRAME    16
`define SIRQ_MGMT_FRAME    3
`define SIRQ_STOP_QUIET    2
`define SIRQ_STOP_CONT     3
`define SIRQ_START_MIN     4
`define SIRQ_START_MAX     8
`define SIRQ_LAT_CLKS      96
`define SIRQ_LAT_NS        (`SIRQ_LAT_CLKS * `SIRQ_CLK_NS)
`define SIRQ_EN2_SERIAL    6
`define SIRQ_EN2_PIN       7
`endif

// ==== hdl/sirq_pkg.sv ====
/*
 types shared by the serial interrupt agent.
 assumes the defs header is included by the agent, which uses its macros.
*/
package sirq_pkg;
   typedef enum logic [2:0] {
      SIRQ_IDLE,
      SIRQ_START,
      SIRQ_DATA,
      SIRQ_STOPWAIT,
      SIRQ_STOPLOW,
      SIRQ_GAP
   } sirq_state_type;
   typedef enum logic [1:0] {
      SIRQ_PH_SAMPLE,
      SIRQ_PH_RECOVER,
      SIRQ_PH_TURN
   } sirq_phase_type;
endpackage

// ==== hdl/sirq_line_capture.sv ====
/*
 per-line level capture and pending-change flags.
 assumes inputs synchronous to sys_clk.
*/
`timescale 1ns/1ns
module sirq_line_capture
   import sirq_pkg::*;
#(
   parameter int NLINES = 16
) (
   input  wire logic              sys_clk,     // bus clock
   input  wire logic              rstn,        // sync reset, low
   input  wire logic              clk_en,      // freeze when low
   input  wire logic [NLINES-1:0] line_in,     // live request levels
   input  wire logic [NLINES-1:0] report_clr,  // reported in finished cycle
   output logic      [NLINES-1:0] level_ff,    // captured levels
   output logic      [NLINES-1:0] pend_ff      // change not yet reported
);
   ////////////////////////////////////////////////////////////////////
   // capture levels; idle high so no spurious low after reset
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         level_ff <= {NLINES{1'b1}};
      end else if (clk_en) begin
         level_ff <= line_in;
      end
   end

   // set wins over clear so an edge in the clearing cycle is kept
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pend_ff <= '0;
      end else if (clk_en) begin
         pend_ff <= (pend_ff & ~report_clr) | (line_in ^ level_ff);
      end
   end
endmodule

// ==== hdl/sirq_agent.sv ====
/*
 device side agent for the serialized interrupt wire.
 assumes wire pin split into in, out and output enable (low = drive),
 with a pull-up outside; all signals synchronous to sys_clk.
*/
`timescale 1ns/1ns
`include "sirq_defs.svh"
module sirq_agent
   import sirq_pkg::*;
#(
   parameter int NFRAMES = `SIRQ_LAST_FRAME,
   parameter int CNTW    = 4
) (
   input  wire logic        sys_clk,                    // bus clock 25 MHz
   input  wire logic        rstn,                       // sync reset, low
   input  wire logic        clk_en,                     // clock enable
   input  wire logic [15:1] irq_level,                  // request lines, low active
   input  wire logic        mgmt_interrupt_frame_source,// mgmt request, low active
   input  wire logic [7:0]  mgmt_enable2,               // mgmt enable register 2
   input  wire logic        sirq_in,                    // wire level
   output logic             sirq_out,                   // wire drive value
   output logic             sirq_oe_n,                  // low = driving
   output logic             mgmt_interrupt_request,     // dedicated mgmt pin
   output logic             quiet_mode                  // sampled mode flag
);
   ////////////////////////////////////////////////////////////////////
   // frame 3 source chooser, used for both serial and pin paths
   function automatic logic mgmt_gated(input logic src, input logic en);
      return en ? src : 1'b1;
   endfunction

   // slots whose sample clock has already been decided in this cycle
   function automatic logic [15:0] slot_mask(input logic [4:0] upto);
      logic [15:0] m;
      m = '0;
      for (int k = 0; k < 16; k++) begin
         m[k] = (5'(k) < upto);
      end
      return m;
   endfunction

   localparam int NL = 16;

   sirq_state_type  state_ff, nxt_state;
   sirq_phase_type  phase_ff, nxt_phase;
   logic [4:0]      frame_ff, nxt_frame;
   logic [CNTW-1:0] low_ff, nxt_low;
   logic            quiet_ff, nxt_quiet;
   logic            drove_ff, nxt_drove;
   logic            out_ff, nxt_out;
   logic            oe_n_ff, nxt_oe_n;
   logic            mgmt_pin_ff;
   logic            sirq_d_ff;
   logic [NL-1:0]   lines;
   logic [NL-1:0]   level;
   logic [NL-1:0]   pend;
   logic [NL-1:0]   rep_clr;
   logic [NL-1:0]   sent_ff;
   logic            want_start;
   logic            rise;
   logic [NL-1:0]   edge_now;

   ////////////////////////////////////////////////////////////////////
   // frame slot map; slot 0 is frame 1 which is never driven
   assign lines[0]     = 1'b1;
   assign lines[1]     = irq_level[1];
   assign lines[2]     = irq_level[2] & mgmt_gated(mgmt_interrupt_frame_source,
                                                   mgmt_enable2[`SIRQ_EN2_SERIAL]);
   assign lines[15:3]  = irq_level[15:3];

   sirq_line_capture #(
      .NLINES (NL)
   ) u_cap (
      .sys_clk    (sys_clk),
      .rstn       (rstn),
      .clk_en     (clk_en),
      .line_in    (lines),
      .report_clr (rep_clr),
      .level_ff   (level),
      .pend_ff    (pend)
   );

   // clear pending only when a full cycle has carried the value
   assign rep_clr = (state_ff == SIRQ_STOPWAIT && sirq_in == 1'b0
                     && state_ff != nxt_state) ? sent_ff : '0;
   assign want_start = |pend;
   assign edge_now   = lines ^ level;
   assign rise       = sirq_in & ~sirq_d_ff;

   ////////////////////////////////////////////////////////////////////
   // wire history for edge detect
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sirq_d_ff <= 1'b1;
      end else if (clk_en) begin
         sirq_d_ff <= sirq_in;
      end
   end

   // dedicated pin path
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mgmt_pin_ff <= 1'b1;
      end else if (clk_en) begin
         mgmt_pin_ff <= mgmt_gated(mgmt_interrupt_frame_source,
                                   mgmt_enable2[`SIRQ_EN2_PIN]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // cycle sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      nxt_frame = frame_ff;
      nxt_low   = low_ff;
      nxt_quiet = quiet_ff;
      nxt_drove = 1'b0;
      nxt_out   = 1'b1;
      nxt_oe_n  = 1'b1;
      unique case (state_ff)
         SIRQ_IDLE, SIRQ_GAP: begin
            if (!sirq_in) begin
               // someone started; host keeps it low
               nxt_state = SIRQ_START;
            end else if (state_ff == SIRQ_IDLE && quiet_ff && want_start) begin
               nxt_out   = 1'b0;
               nxt_oe_n  = 1'b0;
               nxt_state = SIRQ_START;
            end else if (state_ff == SIRQ_GAP) begin
               nxt_state = SIRQ_IDLE;
            end
            // continuous mode: never drive here
         end
         SIRQ_START: begin
            if (rise) begin
               // rising edge of start pulse = clock 0
               nxt_state = SIRQ_DATA;
               nxt_phase = SIRQ_PH_TURN;
               nxt_frame = 5'd0;
            end
         end
         SIRQ_DATA: begin
            unique case (phase_ff)
               SIRQ_PH_TURN: begin
                  if (frame_ff == 5'(NFRAMES)) begin
                     nxt_state = SIRQ_STOPWAIT;
                  end else begin
                     nxt_phase = SIRQ_PH_SAMPLE;
                     nxt_frame = frame_ff + 5'd1;
                     // drive low in the coming sample clock, 3n-1 after edge
                     if (!level[4'(frame_ff)]) begin
                        nxt_out   = 1'b0;
                        nxt_oe_n  = 1'b0;
                        nxt_drove = 1'b1;
                     end
                  end
               end
               SIRQ_PH_SAMPLE: begin
                  nxt_phase = SIRQ_PH_RECOVER;
                  if (drove_ff) begin
                     nxt_out  = 1'b1;
                     nxt_oe_n = 1'b0;
                  end
               end
               SIRQ_PH_RECOVER: begin
                  nxt_phase = SIRQ_PH_TURN;
               end
               default: begin
                  nxt_phase = SIRQ_PH_TURN;
               end
            endcase
         end
         SIRQ_STOPWAIT: begin
            if (!sirq_in) begin
               nxt_state = SIRQ_STOPLOW;
               nxt_low   = CNTW'(1);
            end
         end
         SIRQ_STOPLOW: begin
            if (sirq_in) begin
               // width picks the next cycle mode
               nxt_quiet = (low_ff == CNTW'(`SIRQ_STOP_QUIET));
               nxt_state = SIRQ_GAP;
            end else if (low_ff != {CNTW{1'b1}}) begin
               nxt_low = low_ff + CNTW'(1);
            end
         end
         default: begin
            nxt_state = SIRQ_IDLE;
         end
      endcase
   end

   // state registers; reset releases wire, continuous mode
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_ff <= SIRQ_IDLE;
         phase_ff <= SIRQ_PH_TURN;
         frame_ff <= 5'd0;
         low_ff   <= '0;
         quiet_ff <= 1'b0;
         drove_ff <= 1'b0;
         out_ff   <= 1'b1;
         oe_n_ff  <= 1'b1;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         frame_ff <= nxt_frame;
         low_ff   <= nxt_low;
         quiet_ff <= nxt_quiet;
         drove_ff <= nxt_drove;
         out_ff   <= nxt_out;
         oe_n_ff  <= nxt_oe_n;
      end
   end

   // snapshot of what this cycle carries, so late edges stay pending
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sent_ff <= '0;
      end else if (clk_en) begin
         if (state_ff == SIRQ_START && rise) begin
            sent_ff <= pend;
         end else if (state_ff == SIRQ_DATA) begin
            // a change after its slot was shown must ride the next cycle
            sent_ff <= sent_ff & ~(edge_now & slot_mask((phase_ff == SIRQ_PH_TURN) ?
                                                        frame_ff + 5'd1 : frame_ff));
         end else if (state_ff == SIRQ_STOPWAIT) begin
            sent_ff <= sent_ff & ~edge_now;
         end
      end
   end

   assign sirq_out               = out_ff;
   assign sirq_oe_n              = oe_n_ff;
   assign mgmt_interrupt_request = mgmt_pin_ff;
   assign quiet_mode             = quiet_ff;

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_self_start;
      clk_en && state_ff == SIRQ_IDLE && quiet_ff && want_start && sirq_in;
   endsequence

   sequence s_own_pulse;
      !oe_n_ff && !out_ff && clk_en ##1 oe_n_ff;
   endsequence

   sequence s_turn_to_sample;
      clk_en && state_ff == SIRQ_DATA && phase_ff == SIRQ_PH_TURN
      && frame_ff != 5'(NFRAMES);
   endsequence

   chk_start_one_clock: assert property (@(posedge sys_clk) disable iff (!rstn)
      clk_en && !oe_n_ff && !out_ff && $past(state_ff) == SIRQ_IDLE
      |=> !clk_en || oe_n_ff)
      else $error("start pulse held longer than one clock");

   chk_cont_passive: assert property (@(posedge sys_clk) disable iff (!rstn)
      clk_en && state_ff == SIRQ_IDLE && !quiet_ff |=> oe_n_ff)
      else $error("device started a frame in continuous mode");

   chk_recover_high: assert property (@(posedge sys_clk) disable iff (!rstn)
      clk_en && state_ff == SIRQ_DATA && phase_ff == SIRQ_PH_SAMPLE && !oe_n_ff && !out_ff
      |=> out_ff && !oe_n_ff)
      else $error("recovery high missing after sample low");

   chk_turn_release: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff == SIRQ_DATA && phase_ff == SIRQ_PH_TURN |-> oe_n_ff)
      else $error("wire driven in turnaround");

   chk_never_high_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff == SIRQ_START && !oe_n_ff |-> !out_ff)
      else $error("start driven high");

   chk_stop_mode: assert property (@(posedge sys_clk) disable iff (!rstn)
      clk_en && state_ff == SIRQ_STOPLOW && sirq_in && low_ff == 2
      |=> quiet_ff)
      else $error("two clock stop did not select quiet");

   chk_stop_cont: assert property (@(posedge sys_clk) disable iff (!rstn)
      clk_en && state_ff == SIRQ_STOPLOW && sirq_in && low_ff == 3
      |=> !quiet_ff)
      else $error("three clock stop did not select continuous");

   chk_after_last: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff == SIRQ_STOPWAIT || state_ff == SIRQ_STOPLOW |-> oe_n_ff)
      else $error("wire driven after last frame");

   chk_first_sample: assert property (@(posedge sys_clk) disable iff (!rstn)
      clk_en && state_ff == SIRQ_START && rise ##1 clk_en ##1 clk_en
      |-> phase_ff == SIRQ_PH_SAMPLE && frame_ff == 5'd1)
      else $error("frame 1 sample not at clock 2");

   chk_self_then_host: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_self_start |=> s_own_pulse)
      else $error("pending change did not give a one clock start");

   chk_no_start_busy: assert property (@(posedge sys_clk) disable iff (!rstn)
      clk_en && state_ff != SIRQ_IDLE && !(state_ff == SIRQ_DATA && phase_ff == SIRQ_PH_TURN)
      |=> oe_n_ff || out_ff)
      else $error("low drive outside sample clock or idle start");

   chk_sample_low: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_turn_to_sample ##0 !level[4'(frame_ff)]
      |=> !oe_n_ff && !out_ff && phase_ff == SIRQ_PH_SAMPLE)
      else $error("low level not driven in its sample clock");

   chk_sample_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_turn_to_sample ##0 level[4'(frame_ff)]
      |=> oe_n_ff)
      else $error("high level slot was driven");

   chk_pin_masked: assert property (@(posedge sys_clk) disable iff (!rstn)
      clk_en && !mgmt_enable2[`SIRQ_EN2_PIN] |=> mgmt_interrupt_request)
      else $error("mgmt pin asserted while its enable is clear");

   chk_pin_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
      clk_en && mgmt_enable2[`SIRQ_EN2_PIN]
      |=> mgmt_interrupt_request == $past(mgmt_interrupt_frame_source))
      else $error("mgmt pin does not follow its source");

   chk_reset_release: assert property (@(posedge sys_clk)
      !rstn |=> oe_n_ff && !quiet_ff)
      else $error("wire driven or quiet mode after reset");
endmodule

// ==== tb/sirq_host_model.sv ====
/*
 host controller model for the serial interrupt wire.
 assumes the bench resolves the wire with a pull-up.
*/
`timescale 1ns/1ns
module sirq_host_model (
   input  wire logic sys_clk,  // bus clock
   input  wire logic sirq_in,  // resolved wire level
   output logic      h_out,    // host drive value
   output logic      h_oe_n    // low = host drives
);
   // released from time zero, so also through reset
   initial begin
      h_out  = 1'b1;
      h_oe_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one whole cycle; self_st waits for the agent's one-clock start pulse
   task automatic run(input int slen, input int plen, input bit self_st,
                      output logic [16:1] seen, output bit ok);
      int n;
      ok = 1'b1;
      n = 0;
      if (self_st) begin
         ok = 1'b0;
         while (!ok && n < 6) begin
            @(negedge sys_clk);
            ok = (sirq_in === 1'b0);
            n++;
         end
      end
      @(posedge sys_clk);
      #1;
      h_oe_n = 1'b0;
      h_out  = 1'b0;
      repeat (self_st ? slen - 1 : slen) @(posedge sys_clk);
      #1 h_out = 1'b1;
      @(posedge sys_clk);
      #1 h_oe_n = 1'b1;
      // sampled mid-cycle, well away from the agent's launch edge
      repeat (1) @(negedge sys_clk);
      for (n = 1; n <= 16; n++) begin
         @(negedge sys_clk);
         seen[n] = ~sirq_in;
         @(negedge sys_clk);
         if (sirq_in !== 1'b1) ok = 1'b0;
         @(negedge sys_clk);
      end
      // stop width picks the next mode
      @(posedge sys_clk);
      #1;
      h_oe_n = 1'b0;
      h_out  = 1'b0;
      repeat (plen) @(posedge sys_clk);
      #1 h_out = 1'b1;
      @(posedge sys_clk);
      #1 h_oe_n = 1'b1;
   endtask
endmodule

// ==== tb/tb_top.sv ====
/*
 self-checking bench for the serial interrupt agent.
 assumes the host model owns the far side of the wire.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb_top;
   logic        sys_clk;
   logic        rstn;
   logic        clk_en;
   logic [15:1] irq_level;
   logic        mgmt_src;
   logic [7:0]  en2;
   logic        sirq_wire;
   logic        a_out;
   logic        a_oe_n;
   logic        mgmt_pin;
   logic        quiet;
   logic        h_out;
   logic        h_oe_n;
   logic [16:1] seen;
   bit          ok;
   int          mismatches;
   int          total_checks;
   ////////////////////////////////////////////////////////////////////////////
   // pull-up wins when nobody drives
   assign sirq_wire = !a_oe_n ? a_out : (!h_oe_n ? h_out : 1'b1);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   sirq_agent uut (
      .sys_clk                     (sys_clk),
      .rstn                        (rstn),
      .clk_en                      (clk_en),
      .irq_level                   (irq_level),
      .mgmt_interrupt_frame_source (mgmt_src),
      .mgmt_enable2                (en2),
      .sirq_in                     (sirq_wire),
      .sirq_out                    (a_out),
      .sirq_oe_n                   (a_oe_n),
      .mgmt_interrupt_request      (mgmt_pin),
      .quiet_mode                  (quiet)
   );
   sirq_host_model host (
      .sys_clk (sys_clk),
      .sirq_in (sirq_wire),
      .h_out   (h_out),
      .h_oe_n  (h_oe_n)
   );
   // two drivers at once means the agent spoke out of turn
   always @(negedge sys_clk) begin
      if (!rstn) `CHK(a_oe_n, 1'b1)
      if (a_oe_n === 1'b0 && h_oe_n === 1'b0) `CHK(1'b0, 1'b1)
   end
   ////////////////////////////////////////////////////////////////////////////
   // frame image the host should see
   function automatic logic [16:1] exp_frames(logic [15:1] lv, logic m, logic [7:0] e);
      logic [16:1] f;
      f = {~lv, 1'b0};
      f[3] = ~(lv[2] & (m | ~e[6]));
      return f;
   endfunction
   task automatic drive(logic [15:1] lv, logic m, logic [7:0] e);
      @(posedge sys_clk);
      #1;
      irq_level = lv;
      mgmt_src  = m;
      en2       = e;
   endtask
   task automatic hold_idle(int n);
      repeat (n) begin
         @(negedge sys_clk);
         `CHK(sirq_wire, 1'b1)
      end
   endtask
   // gap 0 runs the next cycle right after the stop turnaround
   task automatic cycle(int plen, bit self_st, int gap);
      host.run(4 + $urandom_range(4), plen, self_st, seen, ok);
      `CHK(ok, 1'b1)
      `CHK(seen, exp_frames(irq_level, mgmt_src, en2))
      `CHK(mgmt_pin, en2[7] ? mgmt_src : 1'b1)
      hold_idle(gap);
      if (gap > 0) `CHK(quiet, plen == 2)
   endtask
   task automatic conclude();
      if (mismatches == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(77844));
      rstn      = 1'b0;
      clk_en    = 1'b1;
      irq_level = 15'h7fff;
      mgmt_src  = 1'b1;
      en2       = 8'h00;
      repeat (4) @(posedge sys_clk);
      #1 rstn = 1'b1;
      `CHK(quiet, 1'b0)
      `CHK(mgmt_pin, 1'b1)
      // a change straight after reset must wait for the host
      drive(15'h7fef, 1'b1, 8'hc0);
      hold_idle(20);
      cycle(3, 1'b0, 4);
      // continuous back to back, then quiet, then a self-started cycle
      for (int i = 0; i < 10; i++) begin
         drive(15'($urandom), 1'($urandom), 8'($urandom));
         cycle(3, 1'b0, 0);
         cycle(2, 1'b0, 3);
         // irq1 always flips, so a change can never hide behind the mgmt gate
         drive(irq_level ^ (15'($urandom) | 15'h0001), 1'($urandom), en2);
         cycle(3, 1'b1, 3);
      end
      // frozen agent must neither capture nor start while clk_en is low
      cycle(2, 1'b0, 3);
      @(posedge sys_clk);
      #1 clk_en = 1'b0;
      drive(irq_level ^ 15'h0001, mgmt_src, en2);
      hold_idle(6);
      `CHK(quiet, 1'b1)
      @(posedge sys_clk);
      #1 clk_en = 1'b1;
      cycle(3, 1'b1, 3);
      // mid-run reset: back to continuous, host must open the next cycle
      cycle(2, 1'b0, 3);
      @(posedge sys_clk);
      #1 rstn = 1'b0;
      drive(irq_level ^ 15'h0100, mgmt_src, en2);
      @(posedge sys_clk);
      #1 rstn = 1'b1;
      `CHK(quiet, 1'b0)
      hold_idle(10);
      cycle(3, 1'b0, 3);
      conclude();
   end
endmodule
